// ===== preset_counter_tacho.sv
// preset counter and tachometer compare logic with ahb-lite registers
`timescale 1ns/100ps
module preset_counter_tacho
	import cnt_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYC
)
(
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// sensor pins
	input wire logic count_pin,
	input wire logic reset_pin,
	// control output
	output logic ctrl_out
);
	// ****************************************
	// declarations
	// ****************************************
	logic [1:0] pin_in;
	logic [1:0] pin_lvl;
	logic [1:0] pin_rise;
	logic count_rise;
	logic reset_lvl;
	logic tick;
	logic wr_pend_r;
	logic [7:0] wr_addr_r;
	logic [2:0] ctrl_r;
	logic [23:0] setv_r;
	logic [23:0] cmp2_r;
	logic [23:0] pscl_r;
	logic [13:0] azt_r;
	logic [23:0] pv_r;
	logic ovf_r;
	logic [23:0] batch_r;
	logic [23:0] acc_r;
	logic [23:0] rate_r;
	logic [3:0] gate_r;
	logic [13:0] idle_r;
	tach_e tst_r;
	tach_e tst_nxt;
	logic rst_act;
	logic tacho;
	logic cnt_ev;
	logic t_ev;
	logic [24:0] pv_sum;
	logic reach;
	logic restart;
	logic gate_end;
	logic lim_ok;
	logic cnt_cmp;
	logic tach_cmp;
	logic out_nxt;
	logic [23:0] pv_show;

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic wr_hit(
		input logic pend,
		input logic [7:0] a,
		input logic [7:0] off
	);
		wr_hit = pend && (a == off);
	endfunction

	// ****************************************
	// pin synchronisers and timebase
	// ****************************************
	assign pin_in = {reset_pin, count_pin};
	generate
		for (genvar i = 0; i < 2; i++)
		begin : g_sync
			pin_sync u_sync
			(
				.hclk(hclk),
				.hresetn(hresetn),
				.pin(pin_in[i]),
				.lvl(pin_lvl[i]),
				.rise(pin_rise[i])
			);
		end
	endgenerate
	assign count_rise = pin_rise[0];
	assign reset_lvl = pin_lvl[1];

	tick_gen #(
		.CYC(TICK_CYCLES)
	) u_tick
	(
		.hclk(hclk),
		.hresetn(hresetn),
		.tick(tick)
	);

	// ****************************************
	// ahb-lite slave
	// ****************************************
	// zero wait states; every access is answered okay
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= 8'h00;
		end
		else if (hready)
		begin
			wr_pend_r <= hsel && htrans[1] && hwrite;
			wr_addr_r <= haddr[7:0];
		end
	end

	// read data captured in the address phase, stands in the data phase
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata <= 32'h00000000;
		else if (hready && hsel && htrans[1] && !hwrite)
		begin
			case (haddr[7:0])
				CTRL_OFF: hrdata <= {29'h0, ctrl_r};
				SETV_OFF: hrdata <= {8'h00, setv_r};
				CMP2_OFF: hrdata <= {8'h00, cmp2_r};
				PSCL_OFF: hrdata <= {8'h00, pscl_r};
				AZT_OFF: hrdata <= {18'h0, azt_r};
				STAT_OFF: hrdata <= {28'h0, tst_r != T_WAIT,
					rst_act, ovf_r && !tacho, ctrl_out};
				PV_OFF: hrdata <= {8'h00, pv_show};
				BATCH_OFF: hrdata <= {8'h00, batch_r};
				RATE_OFF: hrdata <= {8'h00, rate_r};
				default: hrdata <= 32'h00000000;
			endcase
		end
	end

	// ****************************************
	// configuration registers
	// ****************************************
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ctrl_r <= CTRL_RST;
			setv_r <= SETV_RST;
			cmp2_r <= CMP2_RST;
			pscl_r <= PSCL_RST;
			azt_r <= AZT_RST;
		end
		else
		begin
			if (wr_hit(wr_pend_r, wr_addr_r, CTRL_OFF))
				ctrl_r <= hwdata[2:0];
			if (wr_hit(wr_pend_r, wr_addr_r, SETV_OFF))
				setv_r <= hwdata[23:0];
			if (wr_hit(wr_pend_r, wr_addr_r, CMP2_OFF))
				cmp2_r <= hwdata[23:0];
			if (wr_hit(wr_pend_r, wr_addr_r, PSCL_OFF))
				pscl_r <= hwdata[23:0];
			if (wr_hit(wr_pend_r, wr_addr_r, AZT_OFF))
				azt_r <= hwdata[13:0];
		end
	end

	// ****************************************
	// counter operation
	// ****************************************
	assign tacho = ctrl_r[MODE_BIT];
	assign rst_act = reset_lvl || ctrl_r[SRST_BIT];
	assign cnt_ev = count_rise && !tacho && !rst_act && !ovf_r;
	assign pv_sum = {1'b0, pv_r} + {1'b0, pscl_r};
	assign reach = cnt_ev && (pv_sum >= {1'b0, setv_r})
		&& (pv_r < setv_r) && lim_ok;
	assign restart = ctrl_r[BATCH_BIT] && (setv_r != 24'h000000)
		&& (pv_r >= setv_r);
	// all-f only while the overflow also drives the output
	assign pv_show = (ovf_r && !tacho && !rst_act)
		? OVF_SHOW : pv_r;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			pv_r <= 24'h000000;
			ovf_r <= 1'b0;
		end
		else if (rst_act)
		begin
			pv_r <= 24'h000000;
			ovf_r <= 1'b0;
		end
		else if (cnt_ev)
		begin
			// batch restart: the pulse after a full batch starts anew
			if (restart)
				pv_r <= pscl_r;
			else if (pv_sum > {1'b0, MAX_PV})
				ovf_r <= 1'b1;
			else
				pv_r <= pv_sum[23:0];
		end
	end

	// set wins over the software clear
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			batch_r <= 24'h000000;
		else if (reach && ctrl_r[BATCH_BIT])
			batch_r <= batch_r + 24'h000001;
		else if (wr_hit(wr_pend_r, wr_addr_r, BATCH_OFF))
			batch_r <= 24'h000000;
	end

	// sum form avoids underflow when prescale exceeds the maximum
	assign lim_ok = ({1'b0, setv_r} + {1'b0, pscl_r})
		< {1'b0, MAX_PV};
	assign cnt_cmp = ovf_r
		|| ((setv_r == 24'h000000) && (pv_r == 24'h000000))
		|| (lim_ok && (pv_r >= setv_r));

	// ****************************************
	// tachometer operation
	// ****************************************
	assign t_ev = count_rise && tacho && !rst_act;
	assign gate_end = tick && (gate_r == GATE_TICKS - 4'h1);

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			gate_r <= 4'h0;
			acc_r <= 24'h000000;
		end
		else if (!tacho || rst_act)
		begin
			gate_r <= 4'h0;
			acc_r <= 24'h000000;
		end
		else
		begin
			if (gate_end)
				gate_r <= 4'h0;
			else if (tick)
				gate_r <= gate_r + 4'h1;
			if (gate_end)
				acc_r <= {23'h0, t_ev};
			else if (t_ev && (acc_r != OVF_SHOW))
				acc_r <= acc_r + 24'h000001;
		end
	end

	// idle time since the last pulse, in ticks
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			idle_r <= 14'h0000;
		else if (!tacho || rst_act || t_ev)
			idle_r <= 14'h0000;
		else if (tick && (idle_r != azt_r))
			idle_r <= idle_r + 14'h0001;
	end

	always_comb
	begin
		tst_nxt = tst_r;
		case (tst_r)
			T_WAIT:
			begin
				if (gate_end && (acc_r != 24'h000000))
					tst_nxt = T_RUN;
				else if (idle_r == azt_r)
					tst_nxt = T_ZERO;
			end
			T_RUN:
			begin
				if (idle_r == azt_r)
					tst_nxt = T_ZERO;
			end
			T_ZERO:
			begin
				if (gate_end && (acc_r != 24'h000000))
					tst_nxt = T_RUN;
			end
			default:
				tst_nxt = T_WAIT;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			tst_r <= T_WAIT;
			rate_r <= 24'h000000;
		end
		else if (!tacho || rst_act)
		begin
			tst_r <= T_WAIT;
			rate_r <= 24'h000000;
		end
		else
		begin
			tst_r <= tst_nxt;
			if (tst_nxt == T_ZERO)
				rate_r <= 24'h000000;
			else if (gate_end && (acc_r != 24'h000000))
				rate_r <= acc_r;
		end
	end

	// either limit alone would leave a gap; cmp1 >= cmp2 closes it
	assign tach_cmp = (tst_r != T_WAIT)
		&& ((rate_r >= cmp2_r) || (rate_r <= setv_r));

	// ****************************************
	// control output
	// ****************************************
	always_comb
	begin
		if (rst_act)
			out_nxt = 1'b0;
		else if (tacho)
			out_nxt = tach_cmp;
		else
			out_nxt = cnt_cmp;
	end

	// one cycle after the compare; far inside the delay budget
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			ctrl_out <= 1'b0;
		else
			ctrl_out <= out_nxt;
	end
endmodule

// ===== cnt_pkg.sv
// constants shared by the preset counter and tachometer compare block
// Summary of operation
// - The set value is compared with the present value at all times, so a new set value equal to it turns the output on at once.
// - With set value and present value both zero the output is on.
// - While a reset is in progress the output is held off whatever the compare says.
// - Normal compare never turns the output on when the set value is not below the maximum count less the prescale.
// - An overflow of the present value turns the output on and shows all-F digits, whatever the set value.
// - In batch operation the block counts how often the count reaches the set value, at count rates up to 5 kHz.
// - In tachometer operation a change of comparison value is judged at once against the current measurement.
// - With default settings the tachometer turns the output on after 999.9 s with no count pulse since start.
// - In limit mode the output is on, once out of the wait state, while comparison value one is at or above comparison value two.
// - The output goes off shortly after a reset pulse of 1 ms or more, well inside the 0.8 to 1.2 ms reference.
// - The output comes on well inside 0.2 to 0.55 ms after the present value passes the set value.
package cnt_pkg;
	// ****************************************
	// register map, byte offsets
	// ****************************************
	localparam logic [7:0] CTRL_OFF = 8'h00;
	localparam logic [7:0] SETV_OFF = 8'h04;
	localparam logic [7:0] CMP2_OFF = 8'h08;
	localparam logic [7:0] PSCL_OFF = 8'h0c;
	localparam logic [7:0] AZT_OFF = 8'h10;
	localparam logic [7:0] STAT_OFF = 8'h14;
	localparam logic [7:0] PV_OFF = 8'h18;
	localparam logic [7:0] BATCH_OFF = 8'h1c;
	localparam logic [7:0] RATE_OFF = 8'h20;
	// ****************************************
	// field positions and reset values
	// ****************************************
	localparam int MODE_BIT = 0;
	localparam int BATCH_BIT = 1;
	localparam int SRST_BIT = 2;
	localparam int ST_OUT = 0;
	localparam int ST_OVF = 1;
	localparam int ST_RST = 2;
	localparam int ST_VALID = 3;
	localparam logic [2:0] CTRL_RST = 3'h0;
	localparam logic [23:0] SETV_RST = 24'h000000;
	localparam logic [23:0] CMP2_RST = 24'h000000;
	localparam logic [23:0] PSCL_RST = 24'h000001;
	localparam logic [13:0] AZT_RST = 14'h270f;
	localparam logic [23:0] MAX_PV = 24'h0f423f;
	localparam logic [23:0] OVF_SHOW = 24'hffffff;
	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_NS = 100;
	localparam int TICK_MS = 100;
	localparam int TICK_CYC = TICK_MS * 1000000 / CLK_NS;
	localparam logic [3:0] GATE_TICKS = 4'ha;
	typedef enum logic [2:0] {
		T_WAIT = 3'b001,
		T_RUN = 3'b010,
		T_ZERO = 3'b100
	} tach_e;
endpackage

// ===== pin_sync.sv
// three-stage input synchroniser with agreement filter and rise pulse
`timescale 1ns/100ps
module pin_sync
(
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// pin and result
	input wire logic pin,
	output logic lvl,
	output logic rise
);
	logic s1_r;
	logic s2_r;
	logic s3_r;
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
			lvl <= 1'b0;
			rise <= 1'b0;
		end
		else
		begin
			s1_r <= pin;
			s2_r <= s1_r;
			s3_r <= s2_r;
			// change counts only once stages two and three agree
			if (s2_r == s3_r)
				lvl <= s3_r;
			rise <= (s2_r == s3_r) && s3_r && !lvl;
		end
	end
endmodule

// ===== tick_gen.sv
// free-running divider giving a one-cycle tick
`timescale 1ns/100ps
module tick_gen
#(
	parameter int CYC = 1000000
)
(
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// tick out
	output logic tick
);
	logic [23:0] cnt_r;
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			cnt_r <= 24'h000000;
			tick <= 1'b0;
		end
		else
		begin
			tick <= (cnt_r == 24'(CYC - 1));
			if (cnt_r == 24'(CYC - 1))
				cnt_r <= 24'h000000;
			else
				cnt_r <= cnt_r + 24'h000001;
		end
	end
endmodule

// ===== sensor_model.sv
// sensor model driving the count and reset pins
`timescale 1ns/100ps
module sensor_model
(
	// clock
	input wire logic hclk,
	// pins, idle low as with a pull-down
	output logic count_pin,
	output logic reset_pin
);
	initial
	begin
		count_pin = 1'b0;
		reset_pin = 1'b0;
	end
	// ****
	// pulses, h cycles high then h low; h of 2 or more
	// ****
	task automatic pulse(input int n, input int h);
		repeat (n)
		begin
			count_pin <= 1'b1;
			repeat (h) @(posedge hclk);
			count_pin <= 1'b0;
			repeat (h) @(posedge hclk);
		end
	endtask
	// reset held w cycles
	task automatic rst(input int w);
		reset_pin <= 1'b1;
		repeat (w) @(posedge hclk);
		reset_pin <= 1'b0;
	endtask
endmodule

// ===== pct_checker.sv
// assertion checker for the preset counter compare block
`timescale 1ns/100ps
module pct_checker
	import cnt_pkg::*;
(
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// bus
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	// pins
	input wire logic reset_pin,
	input wire logic ctrl_out
);
	// ****
	// data phase tracking
	// ****
	logic rd_r;
	logic wr_r;
	logic [7:0] a_r;
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			rd_r <= 1'b0;
			wr_r <= 1'b0;
			a_r <= 8'h00;
		end
		else if (hready)
		begin
			rd_r <= hsel && htrans[1] && !hwrite;
			wr_r <= hsel && htrans[1] && hwrite;
			a_r <= haddr[7:0];
		end
	end
	wire st = rd_r && a_r == STAT_OFF;
	wire pv = rd_r && a_r == PV_OFF;
	// ****
	// properties
	// ****
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	property p_roff; reset_pin [*8] |-> !ctrl_out; endproperty
	a_roff: assert property (p_roff) else $error("on in reset");
	property p_rdly; $rose(reset_pin) |-> ##[1:8] !ctrl_out; endproperty
	a_rdly: assert property (p_rdly) else $error("slow off");
	property p_zero; $rose(hresetn) && !reset_pin |-> ##[0:2] ctrl_out;
	endproperty
	a_zero: assert property (p_zero) else $error("zero off");
	property p_sout; st |-> hrdata[ST_OUT] == $past(ctrl_out); endproperty
	a_sout: assert property (p_sout) else $error("stat out");
	property p_srst; st && hrdata[ST_RST] |-> !ctrl_out; endproperty
	a_srst: assert property (p_srst) else $error("stat rst");
	property p_sovf; st && hrdata[ST_OVF] && !hrdata[ST_RST] |-> ctrl_out;
	endproperty
	a_sovf: assert property (p_sovf) else $error("stat ovf");
	property p_povf; pv && hrdata[23:0] == OVF_SHOW && !reset_pin
		|-> ctrl_out; endproperty
	a_povf: assert property (p_povf) else $error("pv ovf");
	// soft reset drops the output two edges on
	property p_swr; wr_r && a_r == CTRL_OFF && hwdata[SRST_BIT]
		|-> ##2 !ctrl_out; endproperty
	a_swr: assert property (p_swr) else $error("soft rst");
	c_ovf: cover property (pv && hrdata[23:0] == OVF_SHOW);
	c_rst: cover property (reset_pin [*8]);
	c_sr: cover property (st && hrdata[ST_RST]);
endmodule
bind preset_counter_tacho pct_checker u_chk
(
	.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
	.hwdata, .hready, .hrdata, .reset_pin, .ctrl_out
);

// ===== preset_counter_tacho_compare_tb.sv
// testbench for the preset counter and tachometer compare block
`timescale 1ns/100ps
module preset_counter_tacho_compare_tb
	import cnt_pkg::*;
;
	logic hclk;
	logic hresetn;
	logic hsel;
	logic [31:0] haddr;
	logic [1:0] htrans;
	logic hwrite;
	logic [2:0] hsize;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic count_pin;
	logic reset_pin;
	logic ctrl_out;
	logic [31:0] q;
	int n_mismatch;
	int check_count;
	// short tick so gates and auto-zero fit the run
	preset_counter_tacho #(.TICK_CYCLES(20)) dut
	(
		.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
		.count_pin, .reset_pin, .ctrl_out
	);
	sensor_model sm (.hclk, .count_pin, .reset_pin);
	initial
	begin
		hclk = 1'b0;
		forever #50 hclk = ~hclk;
	end
	// ****
	// tasks
	// ****
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e)
		begin
			n_mismatch++;
			$display("ERROR %0t: got %h want %h", $time, s, e);
		end
	endtask
	task automatic co(input logic e);
		chk({31'h0, ctrl_out}, {31'h0, e});
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge hclk);
	endtask
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= {24'h000000, a};
		@(posedge hclk);
		while (!hreadyout) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		@(posedge hclk);
		while (!hreadyout) @(posedge hclk);
		q = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(q, e);
		chk({31'h0, hresp}, 32'h0);
	endtask
	task automatic cnt(input int n);
		sm.pulse(n, 4);
		cyc(2);
	endtask
	task automatic srst(input logic [31:0] m);
		wr(CTRL_OFF, 32'h4);
		cyc(2);
		bus(1'b0, STAT_OFF, 32'h0);
		chk({29'h0, q[2:0]}, 32'h4);
		wr(CTRL_OFF, m);
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// ****
	// tests
	// ****
	initial
	begin
		#2000000;
		n_mismatch++;
		final_report;
	end
	initial
	begin
		n_mismatch = 0;
		check_count = 0;
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		cyc(5);
		hresetn <= 1'b1;
		cyc(3);
		co(1'b1);
		rd(PSCL_OFF, 32'h1);
		rd(AZT_OFF, 32'h270f);
		rd(8'h24, 32'h0);
		fork
			sm.rst(10);
			begin
				cyc(8);
				co(1'b0);
			end
		join
		cyc(6);
		co(1'b1);
		wr(PSCL_OFF, 32'h3);
		wr(SETV_OFF, 32'h6);
		cnt(1);
		co(1'b0);
		rd(PV_OFF, 32'h3);
		cnt(1);
		co(1'b1);
		wr(SETV_OFF, 32'h9);
		cyc(2);
		co(1'b0);
		wr(SETV_OFF, 32'h6);
		cyc(2);
		co(1'b1);
		// sum of set value and prescale at the limit
		srst(32'h0);
		wr(PSCL_OFF, 32'h7a120);
		wr(SETV_OFF, 32'h7a11f);
		cnt(1);
		co(1'b0);
		wr(SETV_OFF, 32'h7a11e);
		cyc(2);
		co(1'b1);
		wr(SETV_OFF, 32'hf423f);
		cyc(2);
		co(1'b0);
		cnt(1);
		co(1'b1);
		rd(PV_OFF, 32'hffffff);
		bus(1'b0, STAT_OFF, 32'h0);
		chk({30'h0, q[1:0]}, 32'h3);
		srst(32'h2);
		wr(PSCL_OFF, 32'h1);
		wr(SETV_OFF, 32'h2);
		wr(BATCH_OFF, 32'h0);
		cnt(4);
		rd(BATCH_OFF, 32'h2);
		rd(PV_OFF, 32'h2);
		wr(BATCH_OFF, 32'h0);
		cyc(1);
		rd(BATCH_OFF, 32'h0);
		srst(32'h1);
		wr(AZT_OFF, 32'h3);
		wr(SETV_OFF, 32'h0);
		cyc(100);
		co(1'b1);
		rd(RATE_OFF, 32'h0);
		rd(STAT_OFF, 32'h9);
		// steady train of 25 pulses per gate
		fork
			sm.pulse(75, 4);
			begin
				cyc(450);
				rd(RATE_OFF, 32'h19);
				wr(CMP2_OFF, 32'h28);
				wr(SETV_OFF, 32'h1e);
				cyc(2);
				co(1'b1);
				wr(SETV_OFF, 32'ha);
				cyc(2);
				co(1'b0);
				wr(CMP2_OFF, 32'h19);
				cyc(2);
				co(1'b1);
				wr(CMP2_OFF, 32'h5);
				wr(SETV_OFF, 32'h28);
				cyc(2);
				co(1'b1);
			end
		join
		final_report;
	end
endmodule
